// >>> hw/gd_pkg.sv
package gd_pkg;
	localparam int CLK_MHZ = 200;
	localparam int T_DEAD_STEP_NS = 250;
	localparam int T_BLANK0_NS = 500;
	localparam int T_BLANK1_NS = 1000;
	localparam int T_BLANK2_NS = 2000;
	localparam int T_BLANK3_NS = 4000;
	localparam int T_DUV_FILT_NS = 1000;
	localparam int T_STARTUP_US = 35;
	localparam int T_CE_STBY_US = 1000;
	localparam int T_WAKE_EN_US = 250;
	localparam int T_WAKE_BUS_US = 150;
	localparam int T_WAKE_HV_US = 250;
	localparam int T_SLEEP_US = 100;
	localparam logic [9:0] DEAD_STEP_CYC = 10'((T_DEAD_STEP_NS * CLK_MHZ + 999) / 1000);
	localparam logic [9:0] BLANK0_CYC = 10'((T_BLANK0_NS * CLK_MHZ + 999) / 1000);
	localparam logic [9:0] BLANK1_CYC = 10'((T_BLANK1_NS * CLK_MHZ + 999) / 1000);
	localparam logic [9:0] BLANK2_CYC = 10'((T_BLANK2_NS * CLK_MHZ + 999) / 1000);
	localparam logic [9:0] BLANK3_CYC = 10'((T_BLANK3_NS * CLK_MHZ + 999) / 1000);
	localparam logic [9:0] DUV_FILT_CYC = 10'((T_DUV_FILT_NS * CLK_MHZ + 999) / 1000);
	localparam logic [17:0] STARTUP_CYC = 18'(T_STARTUP_US * CLK_MHZ);
	localparam logic [17:0] CE_STBY_CYC = 18'(T_CE_STBY_US * CLK_MHZ);
	localparam logic [17:0] WAKE_EN_CYC = 18'(T_WAKE_EN_US * CLK_MHZ);
	localparam logic [17:0] WAKE_BUS_CYC = 18'(T_WAKE_BUS_US * CLK_MHZ);
	localparam logic [17:0] WAKE_HV_CYC = 18'(T_WAKE_HV_US * CLK_MHZ);
	localparam logic [17:0] SLEEP_CYC = 18'(T_SLEEP_US * CLK_MHZ);
	// config reset values
	localparam logic [2:0] DEAD_SEL_RST = 3'h7;
	localparam logic [1:0] BLANK_SEL_RST = 2'h3;
	localparam logic [1:0] SC_THR_RST = 2'h0;
	localparam logic SC_EN_RST = 1'h1;
	localparam logic UVL_EN_RST = 1'h1;
	localparam logic SLEEP_RST = 1'h0;
	// status byte 0x85 bit positions
	localparam int S0_TEMP_WARN = 0;
	localparam int S0_OVER_TEMP = 1;
	localparam int S0_VIN_UV = 2;
	localparam int S0_DRV_OV = 3;
	localparam int S0_VIN_OV = 4;
	localparam int S0_BUCK_OC = 5;
	localparam int S0_BUCK_UVW = 6;
	localparam int S0_BUCK_UV = 7;
	// status byte 0x86 bit positions
	localparam int S1_EXT_UV = 2;
	localparam int S1_EXT_OC = 3;
	localparam int S1_BROWNOUT = 4;
	localparam int S1_LDO5_UV = 5;
	localparam logic [7:0] S0_FAULT_MASK = 8'h9e;
	localparam logic [7:0] S1_FAULT_MASK = 8'h2c;
	localparam logic [7:0] S0_BUCK_MASK = 8'h80;
	typedef enum logic [2:0] {
		ST_START = 3'h0,
		ST_ACTIVE = 3'h1,
		ST_OFF = 3'h2,
		ST_STANDBY = 3'h3,
		ST_SLEEP_PEND = 3'h4,
		ST_SLEEP = 3'h5
	} gd_mode_e;
endpackage

// >>> hw/gd_sync.sv
`timescale 1ns/10ps
`default_nettype none
module gd_sync #(
	parameter int W = 1
) (
	// clock and reset
	input  wire logic         clock,
	input  wire logic         arst_n,
	// data
	input  wire logic [W-1:0] async_in,
	output var  logic [W-1:0] sync_out
);
	logic [W-1:0] meta_reg;

	for (genvar i = 0; i < W; i++) begin : g_bit
		always_ff @(posedge clock or negedge arst_n) begin
			if (!arst_n) begin
				meta_reg[i] <= 1'b0;
				sync_out[i] <= 1'b0;
			end else begin
				meta_reg[i] <= async_in[i];
				sync_out[i] <= meta_reg[i];
			end
		end
	end
endmodule
`default_nettype wire

// >>> hw/gd_top.sv
`timescale 1ns/10ps
`default_nettype none
module gd_top
	import gd_pkg::*;
#(
	parameter logic [17:0] P_STARTUP_CYC  = STARTUP_CYC,
	parameter logic [17:0] P_CE_STBY_CYC  = CE_STBY_CYC,
	parameter logic [17:0] P_WAKE_EN_CYC  = WAKE_EN_CYC,
	parameter logic [17:0] P_WAKE_BUS_CYC = WAKE_BUS_CYC,
	parameter logic [17:0] P_WAKE_HV_CYC  = WAKE_HV_CYC,
	parameter logic [17:0] P_SLEEP_CYC    = SLEEP_CYC
) (
	// clock and reset
	input  wire logic       clock,
	input  wire logic       arst_n,
	// pins from host
	input  wire logic [2:0] cmd_high,
	input  wire logic [2:0] cmd_low,
	input  wire logic       chip_en,
	input  wire logic       bus_rx,
	input  wire logic       high_voltage_wake_input,
	// analog monitors, switch order high a..c then low a..c
	input  wire logic [5:0] sc_detect_raw,
	input  wire logic [5:0] drv_bias_low_raw,
	input  wire logic [8:0] monitor_raw,
	// variant and configuration from the single wire port logic
	input  wire logic       variant_xcvr,
	input  wire logic       cfg_write,
	input  wire logic [1:0] cfg_sc_threshold_sel,
	input  wire logic       cfg_sc_detect_en,
	input  wire logic       cfg_driver_uv_lockout_en,
	input  wire logic [2:0] cfg_dead_time_sel,
	input  wire logic [1:0] cfg_blanking_time_sel,
	input  wire logic       sleep_cmd,
	// gate drives
	output var  logic [2:0] gate_high,
	output var  logic [2:0] gate_low,
	// open-drain fault pin
	output var  logic       fault_flag_out_o,
	output var  logic       fault_flag_out_oe,
	// status to the single wire port logic
	output var  logic [7:0] status_byte0,
	output var  logic [7:0] status_byte1,
	output var  logic       msg_req,
	output var  logic [1:0] sc_threshold_sel,
	// power control
	output var  logic       reg12_en,
	output var  logic       reg5_en,
	output var  logic       pullup_en,
	output var  logic       buck_en,
	output var  logic       standby,
	output var  logic       sleeping
);
	typedef struct packed {
		gd_mode_e          mode;
		logic [17:0]       cnt;
		logic [2:0][17:0]  low_cnt;
		logic [2:0]        wake_prev;
		logic              en_prev;
		logic [5:0][9:0]   tmr;
		logic [5:0]        dt_done;
		logic [5:0]        bl_done;
		logic [5:0]        gate;
		logic [5:0]        uv_lock;
		logic [2:0]        dead_sel;
		logic [1:0]        blank_sel;
		logic [1:0]        sc_thr;
		logic              sc_en;
		logic              uvl_en;
		logic              sleep_set;
		logic [7:0]        st0;
		logic [7:0]        st1;
		logic              msg_pend;
		logic              msg;
		logic              fault_oe;
		logic [5:0]        pwr;
	} gd_state_s;

	gd_state_s state_reg;
	gd_state_s state_next;

	logic [29:0] sync_vec;
	logic [5:0]  cmd_s;
	logic        en_s;
	logic        bus_s;
	logic        hv_s;
	logic [5:0]  sc_s;
	logic [5:0]  uv_s;
	logic [8:0]  mon_s;

	gd_sync #(
		.W(30)
	) u_sync (
		.clock   (clock),
		.arst_n  (arst_n),
		.async_in({cmd_low, cmd_high, chip_en, bus_rx, high_voltage_wake_input,
			sc_detect_raw, drv_bias_low_raw, monitor_raw}),
		.sync_out(sync_vec)
	);

	assign {cmd_s, en_s, bus_s, hv_s, sc_s, uv_s, mon_s} = sync_vec;

	always_comb begin
		logic [9:0]  dt_cyc;
		logic [9:0]  bl_cyc;
		logic [5:0]  want;
		logic [7:0]  set0;
		logic [7:0]  set1;
		logic [7:0]  clr0;
		logic [7:0]  clr1;
		logic        en_rise;
		logic        fault_any;
		logic        buck_fault;
		logic        run;
		logic        wake;
		logic [2:0]  wake_lvl;
		logic [2:0]  wake_ok;
		logic [2:0][17:0] wake_lim;
		state_next = state_reg;
		en_rise = en_s && !state_reg.en_prev;
		dt_cyc = 10'(DEAD_STEP_CYC * ({7'h00, state_reg.dead_sel} + 10'h001));
		case (state_reg.blank_sel)
			2'h0: bl_cyc = BLANK0_CYC;
			2'h1: bl_cyc = BLANK1_CYC;
			2'h2: bl_cyc = BLANK2_CYC;
			default: bl_cyc = BLANK3_CYC;
		endcase
		fault_any = |(state_reg.st0 & S0_FAULT_MASK) | |(state_reg.st1 & S1_FAULT_MASK);
		buck_fault = |(state_reg.st0 & S0_BUCK_MASK) || mon_s[S0_BUCK_UV];
		run = (state_reg.mode == ST_ACTIVE) && en_s && !fault_any;
		set0 = mon_s[7:0];
		set1 = 8'h00;
		set1[S1_LDO5_UV] = mon_s[8];
		clr0 = 8'h00;
		clr1 = 8'h00;
		state_next.en_prev = en_s;
		// gate control per switch
		for (int i = 0; i < 6; i++) begin
			want[i] = cmd_s[i] && !(cmd_s[i % 3] && cmd_s[3 + (i % 3)])
				&& run && !state_reg.uv_lock[i];
			if (!want[i]) begin
				state_next.tmr[i] = 10'h000;
				state_next.dt_done[i] = 1'b0;
				state_next.bl_done[i] = 1'b0;
				state_next.gate[i] = 1'b0;
			end else if (!state_reg.dt_done[i]) begin
				if (state_reg.tmr[i] >= dt_cyc - 10'h001) begin
					state_next.dt_done[i] = 1'b1;
					state_next.gate[i] = 1'b1;
					state_next.tmr[i] = 10'h000;
				end else begin
					state_next.tmr[i] = state_reg.tmr[i] + 10'h001;
				end
			end else if (!state_reg.bl_done[i]) begin
				if (state_reg.tmr[i] >= bl_cyc - 10'h001) begin
					state_next.bl_done[i] = 1'b1;
					state_next.tmr[i] = 10'h000;
				end else begin
					state_next.tmr[i] = state_reg.tmr[i] + 10'h001;
				end
			end else begin
				if (sc_s[i] && state_reg.sc_en) begin
					set1[S1_EXT_OC] = 1'b1;
				end
				if (uv_s[i] && state_reg.uvl_en) begin
					state_next.tmr[i] = state_reg.tmr[i] + 10'h001;
					if (state_reg.tmr[i] >= DUV_FILT_CYC - 10'h001) begin
						set1[S1_EXT_UV] = 1'b1;
						state_next.uv_lock[i] = 1'b1;
						state_next.tmr[i] = 10'h000;
					end
				end else begin
					state_next.tmr[i] = 10'h000;
				end
			end
		end
		// configuration
		if (cfg_write) begin
			state_next.sc_thr = cfg_sc_threshold_sel;
			state_next.sc_en = cfg_sc_detect_en;
			state_next.uvl_en = cfg_driver_uv_lockout_en;
			state_next.dead_sel = cfg_dead_time_sel;
			state_next.blank_sel = cfg_blanking_time_sel;
		end
		if (sleep_cmd) begin
			state_next.sleep_set = 1'b1;
		end
		// wake detectors: enable pin, bus, high voltage input
		wake_lvl = {hv_s, bus_s, en_s};
		wake_lim = {P_WAKE_HV_CYC, P_WAKE_BUS_CYC, P_WAKE_EN_CYC};
		for (int k = 0; k < 3; k++) begin
			wake_ok[k] = wake_lvl[k] && !state_reg.wake_prev[k]
				&& (state_reg.low_cnt[k] >= wake_lim[k]);
			if (wake_lvl[k] || state_reg.mode != ST_SLEEP) begin
				state_next.low_cnt[k] = 18'h00000;
			end else if (state_reg.low_cnt[k] != 18'h3ffff) begin
				state_next.low_cnt[k] = state_reg.low_cnt[k] + 18'h00001;
			end
		end
		state_next.wake_prev = wake_lvl;
		wake = wake_ok[0] || (variant_xcvr && wake_ok[1])
			|| (!variant_xcvr && wake_ok[2]);
		// mode control
		state_next.cnt = state_reg.cnt + 18'h00001;
		case (state_reg.mode)
			ST_START: begin
				if (!en_s) begin
					state_next.mode = ST_OFF;
					state_next.cnt = 18'h00000;
				end else if (state_reg.cnt >= P_STARTUP_CYC - 18'h00001) begin
					state_next.mode = ST_ACTIVE;
				end
			end
			ST_ACTIVE: begin
				if (!en_s) begin
					state_next.mode = ST_OFF;
					state_next.cnt = 18'h00000;
				end
			end
			ST_OFF: begin
				if (en_rise) begin
					state_next.mode = ST_START;
					state_next.cnt = 18'h00000;
				end else if (state_reg.sleep_set) begin
					state_next.mode = ST_SLEEP_PEND;
					state_next.cnt = 18'h00000;
				end else if (state_reg.cnt >= P_CE_STBY_CYC - 18'h00001) begin
					state_next.mode = ST_STANDBY;
				end
			end
			ST_STANDBY: begin
				if (en_rise) begin
					state_next.mode = ST_START;
					state_next.cnt = 18'h00000;
				end else if (state_reg.sleep_set) begin
					state_next.mode = ST_SLEEP_PEND;
					state_next.cnt = 18'h00000;
				end
			end
			ST_SLEEP_PEND: begin
				if (en_rise) begin
					state_next.mode = ST_START;
					state_next.cnt = 18'h00000;
				end else if (buck_fault) begin
					state_next.cnt = 18'h00000;
				end else if (state_reg.cnt >= P_SLEEP_CYC - 18'h00001) begin
					state_next.mode = ST_SLEEP;
					set1[S1_BROWNOUT] = 1'b1;
					state_next.sc_thr = SC_THR_RST;
					state_next.sc_en = SC_EN_RST;
					state_next.uvl_en = UVL_EN_RST;
					state_next.dead_sel = DEAD_SEL_RST;
					state_next.blank_sel = BLANK_SEL_RST;
					state_next.sleep_set = SLEEP_RST;
				end
			end
			ST_SLEEP: begin
				state_next.cnt = 18'h00000;
				if (wake) begin
					state_next.mode = ST_START;
				end
			end
			default: begin
				state_next.mode = ST_OFF;
			end
		endcase
		// status: ended conditions clear on enable rise outside sleep, set wins
		if (en_rise && state_reg.mode != ST_SLEEP) begin
			clr0 = ~mon_s[7:0];
			clr1 = 8'hff;
			clr1[S1_LDO5_UV] = !mon_s[8];
			state_next.uv_lock = state_next.uv_lock & ~state_reg.uv_lock;
		end
		state_next.st0 = (state_reg.st0 & ~clr0) | set0;
		state_next.st1 = (state_reg.st1 & ~clr1) | set1;
		state_next.msg = 1'b0;
		if (|(set0 & ~state_reg.st0) || |(set1 & ~state_reg.st1)) begin
			state_next.msg_pend = 1'b1;
		end
		if (state_reg.msg_pend && en_s && !state_reg.msg) begin
			state_next.msg = 1'b1;
			state_next.msg_pend = 1'b0;
		end
		state_next.fault_oe = |(state_next.st0 & S0_FAULT_MASK)
			| |(state_next.st1 & S1_FAULT_MASK);
		if (state_next.fault_oe) begin
			state_next.gate = 6'h00;
		end
		// power: 12V, 5V, pull-up, buck, standby, sleep
		state_next.pwr = 6'h0f;
		if (state_next.mode == ST_STANDBY || state_next.mode == ST_SLEEP_PEND) begin
			state_next.pwr = {1'b0, 1'b1, 1'b1, 1'b0, variant_xcvr, 1'b0};
		end else if (state_next.mode == ST_SLEEP) begin
			state_next.pwr = 6'h20;
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			state_reg <= '0;
			state_reg.mode <= ST_OFF;
			state_reg.dead_sel <= DEAD_SEL_RST;
			state_reg.blank_sel <= BLANK_SEL_RST;
			state_reg.sc_thr <= SC_THR_RST;
			state_reg.sc_en <= SC_EN_RST;
			state_reg.uvl_en <= UVL_EN_RST;
			state_reg.sleep_set <= SLEEP_RST;
			state_reg.pwr <= 6'h0f;
		end else begin
			state_reg <= state_next;
		end
	end

	assign gate_high = state_reg.gate[2:0];
	assign gate_low = state_reg.gate[5:3];
	assign fault_flag_out_o = 1'b0;
	assign fault_flag_out_oe = state_reg.fault_oe;
	assign status_byte0 = state_reg.st0;
	assign status_byte1 = state_reg.st1;
	assign msg_req = state_reg.msg;
	assign sc_threshold_sel = state_reg.sc_thr;
	assign {sleeping, standby, buck_en, pullup_en, reg5_en, reg12_en} = state_reg.pwr;
endmodule
`default_nettype wire

// >>> test/gd_bridge_model.sv
`timescale 1ns/10ps
`default_nettype none
module gd_bridge_model (
	// gate drives from the block
	input  wire logic [2:0] gate_high,
	input  wire logic [2:0] gate_low,
	// faults planted by the bench
	input  wire logic [5:0] short_sel,
	input  wire logic [5:0] bias_sel,
	// comparator and bias monitors
	output var  logic [5:0] sc_detect_raw,
	output var  logic [5:0] drv_bias_low_raw
);
	logic [5:0] on_now;
	assign on_now = {gate_low, gate_high};
	// an off switch reads high while its partner holds the phase node
	assign sc_detect_raw = (on_now & short_sel) | (~on_now & {gate_high, gate_low});
	assign drv_bias_low_raw = bias_sel;
endmodule
`default_nettype wire

// >>> test/gd_chk_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module gd_chk_assertions (
	// clock and reset
	input wire logic       clock,
	input wire logic       arst_n,
	// host pins
	input wire logic [2:0] cmd_high,
	input wire logic [2:0] cmd_low,
	input wire logic       chip_en,
	// block outputs
	input wire logic [2:0] gate_high,
	input wire logic [2:0] gate_low,
	input wire logic       fault_flag_out_oe,
	input wire logic [7:0] status_byte0,
	input wire logic [7:0] status_byte1,
	input wire logic       msg_req,
	input wire logic       reg12_en,
	input wire logic       buck_en,
	input wire logic       standby,
	input wire logic       sleeping
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!arst_n);
	a_cross_both_off: assert property (
		($stable(cmd_high & cmd_low))[*4] |-> ((gate_high | gate_low) & cmd_high & cmd_low) == 3'h0)
		else $error("both gates of a commanded pair on");
	a_no_overlap: assert property ((gate_high & gate_low) == 3'h0)
		else $error("high and low gate of one phase on together");
	a_dead_min: assert property ($rose(gate_high[0]) |-> $past(cmd_high[0], 50))
		else $error("gate rose before the shortest dead time");
	a_off_disabled: assert property ((!chip_en)[*5] |-> (gate_high | gate_low) == 3'h0)
		else $error("gate on while disabled");
	a_fault_gates: assert property (fault_flag_out_oe |-> (gate_high | gate_low) == 3'h0)
		else $error("gate on while fault pin low");
	a_sc_latch: assert property (
		$rose(status_byte1[3]) |-> fault_flag_out_oe && (gate_high | gate_low) == 3'h0)
		else $error("short circuit without fault pin or gate stop");
	a_sc_held: assert property (chip_en[*8] ##0 status_byte1[3] |=> status_byte1[3])
		else $error("short circuit flag dropped while enabled");
	a_msg_quiet: assert property ((!chip_en)[*4] |-> !msg_req)
		else $error("message started while disabled");
	a_sleep_buck: assert property ($rose(sleeping) |-> !$past(status_byte0[7]))
		else $error("sleep entered with buck fault");
	a_sleep_bor: assert property ($rose(sleeping) |-> ##[0:2] status_byte1[4])
		else $error("sleep entry without brown-out flag");
	a_standby_pwr: assert property (
		standby |-> !reg12_en && buck_en && (gate_high | gate_low) == 3'h0)
		else $error("standby power state wrong");
	c_short: cover property ($rose(status_byte1[3]));
	c_sleep: cover property ($rose(sleeping));
	c_standby: cover property ($rose(standby));
	c_gate: cover property ($rose(gate_high[0]));
endmodule
bind gd_top gd_chk_assertions chk_u (.clock, .arst_n, .cmd_high, .cmd_low, .chip_en,
	.gate_high, .gate_low, .fault_flag_out_oe, .status_byte0, .status_byte1, .msg_req,
	.reg12_en, .buck_en, .standby, .sleeping);
`default_nettype wire

// >>> test/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb import gd_pkg::*; ;
	logic       clock = 1'b0, arst_n = 1'b0, chip_en = 1'b0, bus_rx = 1'b1;
	logic       high_voltage_wake_input = 1'b1, variant_xcvr = 1'b1, cfg_write = 1'b0;
	logic       sleep_cmd = 1'b0, cfg_sc_detect_en = 1'b1, cfg_driver_uv_lockout_en = 1'b1;
	logic [2:0] cmd_high = 3'h0, cmd_low = 3'h0, cfg_dead_time_sel = 3'h7, gate_high, gate_low;
	logic [1:0] cfg_sc_threshold_sel = 2'h0, cfg_blanking_time_sel = 2'h3, sc_threshold_sel;
	logic [8:0] monitor_raw = 9'h0;
	logic [5:0] short_sel = 6'h0, bias_sel = 6'h0, sc_detect_raw, drv_bias_low_raw;
	logic [7:0] status_byte0, status_byte1;
	logic       fault_flag_out_o, fault_flag_out_oe, msg_req, reg12_en, reg5_en;
	logic       pullup_en, buck_en, standby, sleeping;
	int         failures = 0, check_count = 0, cycles = 0, msgs = 0;
	// open-drain fault line with its pull-up
	wire logic  fault_pin_n = fault_flag_out_oe ? fault_flag_out_o : 1'b1;

	gd_top #(.P_STARTUP_CYC(18'h14), .P_CE_STBY_CYC(18'h64), .P_WAKE_EN_CYC(18'h28),
		.P_WAKE_HV_CYC(18'h28), .P_SLEEP_CYC(18'h14)) dut_u (
		.clock, .arst_n, .cmd_high, .cmd_low, .chip_en, .bus_rx, .high_voltage_wake_input,
		.sc_detect_raw, .drv_bias_low_raw, .monitor_raw, .variant_xcvr, .cfg_write,
		.cfg_sc_threshold_sel, .cfg_sc_detect_en, .cfg_driver_uv_lockout_en,
		.cfg_dead_time_sel, .cfg_blanking_time_sel, .sleep_cmd, .gate_high, .gate_low,
		.fault_flag_out_o, .fault_flag_out_oe, .status_byte0, .status_byte1, .msg_req,
		.sc_threshold_sel, .reg12_en, .reg5_en, .pullup_en, .buck_en, .standby, .sleeping);
	gd_bridge_model bridge_u (.gate_high, .gate_low, .short_sel, .bias_sel, .sc_detect_raw,
		.drv_bias_low_raw);

	always #2.5 clock = ~clock;

	task automatic finish_test;
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (msg_req === 1'b1)
			msgs <= msgs + 1;
		if (cycles == 60000) begin
			failures++;
			finish_test();
		end
	end

	task automatic tick(input int n);
		repeat (n) @(posedge clock);
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			failures++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic cfg(input logic [2:0] dt, input logic [1:0] bt, input logic [1:0] thr,
		input logic sc, input logic uvl);
		cfg_dead_time_sel <= dt;
		cfg_blanking_time_sel <= bt;
		cfg_sc_threshold_sel <= thr;
		cfg_sc_detect_en <= sc;
		cfg_driver_uv_lockout_en <= uvl;
		cfg_write <= 1'b1;
		tick(1);
		cfg_write <= 1'b0;
		tick(3);
	endtask

	task automatic en_pulse(input int n);
		chip_en <= 1'b0;
		tick(n);
		chip_en <= 1'b1;
		tick(40);
	endtask

	task automatic pulse_sleep;
		sleep_cmd <= 1'b1;
		tick(1);
		sleep_cmd <= 1'b0;
	endtask

	// cycles until gate bit b (high a..c, low a..c) is seen on
	task automatic wait_on(input int b, output int n);
		logic [5:0] g;
		n = 0;
		g = {gate_low, gate_high};
		while (g[b] !== 1'b1 && n < 3000) begin
			tick(1);
			n++;
			g = {gate_low, gate_high};
		end
	endtask

	task automatic t_dead;
		int n;
		for (int d = 0; d < 8; d++) begin
			cfg(3'(d), 2'h0, 2'h0, 1'b0, 1'b1);
			cmd_low <= 3'h4;
			wait_on(5, n);
			check(n >= (d + 1) * 50 && n <= (d + 1) * 50 + 6, 1'b1);
			cmd_low <= 3'h0;
			tick(6);
			check(gate_low, 3'h0);
		end
		cfg(3'h0, 2'h0, 2'h0, 1'b0, 1'b1);
		cmd_high <= 3'h3;
		cmd_low <= 3'h6;
		tick(120);
		check({gate_high, gate_low}, 6'h0c);
		cmd_high <= 3'h0;
		cmd_low <= 3'h0;
		tick(6);
	endtask

	task automatic t_short;
		int n;
		int m;
		int m0;
		for (int b = 0; b < 4; b++) begin
			cfg(3'h0, 2'(b), 2'(b), 1'b1, 1'b1);
			check(sc_threshold_sel, b);
			short_sel <= 6'h20;
			cmd_low <= 3'h4;
			m0 = msgs;
			wait_on(5, n);
			m = 0;
			while (status_byte1[3] !== 1'b1 && m < 3000) begin
				tick(1);
				m++;
			end
			check(m >= (100 << b) - 2 && m <= (100 << b) + 8, 1'b1);
			tick(3);
			check({gate_high, gate_low, fault_pin_n, msgs > m0}, 8'h01);
			short_sel <= 6'h0;
			cmd_low <= 3'h0;
			en_pulse(10);
			check({status_byte1[3], fault_pin_n}, 2'h1);
		end
		cfg(3'h0, 2'h0, 2'h0, 1'b0, 1'b1);
		short_sel <= 6'h20;
		cmd_low <= 3'h4;
		tick(300);
		check({status_byte1[3], gate_low}, 4'h4);
		short_sel <= 6'h0;
		cmd_low <= 3'h0;
		tick(6);
	endtask

	task automatic t_uv;
		int n;
		for (int u = 0; u < 2; u++) begin
			cfg(3'h0, 2'h0, 2'h0, 1'b1, 1'(u));
			bias_sel <= 6'h01;
			cmd_high <= 3'h1;
			wait_on(0, n);
			tick(240);
			check(status_byte1[2], 1'b0);
			tick(100);
			check({status_byte1[2], fault_pin_n, gate_high[0]}, u ? 3'h4 : 3'h3);
			bias_sel <= 6'h0;
			cmd_high <= 3'h0;
			en_pulse(10);
		end
	endtask

	task automatic t_mon;
		int m0;
		logic [9:0] ex;
		for (int i = 0; i < 9; i++) begin
			monitor_raw <= 9'h1 << i;
			tick(8);
			ex = {9'h1 << i, !(i == 8 || S0_FAULT_MASK[i % 8])};
			check({status_byte1[S1_LDO5_UV], status_byte0, fault_pin_n}, ex);
			m0 = msgs;
			en_pulse(10);
			check({status_byte1[S1_LDO5_UV], status_byte0, fault_pin_n}, ex);
			check(msgs, m0);
			monitor_raw <= 9'h0;
			en_pulse(10);
			check({status_byte1[S1_LDO5_UV], status_byte0, fault_pin_n}, 10'h1);
		end
	endtask

	task automatic t_standby;
		int n;
		for (int v = 0; v < 2; v++) begin
			variant_xcvr <= 1'(v);
			chip_en <= 1'b0;
			tick(60);
			check(standby, 1'b0);
			tick(60);
			check({standby, reg12_en, pullup_en, buck_en, reg5_en}, {4'h9, 1'(v)});
			chip_en <= 1'b1;
			cmd_high <= 3'h1;
			wait_on(0, n);
			check(n >= 20 && n <= 85 && standby === 1'b0, 1'b1);
			cmd_high <= 3'h0;
			tick(6);
		end
	endtask

	task automatic t_sleep;
		for (int v = 0; v < 2; v++) begin
			variant_xcvr <= 1'(v);
			cfg(3'h0, 2'h0, 2'h2, 1'b1, 1'b1);
			pulse_sleep();
			chip_en <= 1'b0;
			tick(40);
			check({sleeping, buck_en, status_byte1[4]}, 3'h5);
			if (v) begin
				bus_rx <= 1'b0;
				tick(20);
				bus_rx <= 1'b1;
				tick(8);
				check(sleeping, 1'b1);
				bus_rx <= 1'b0;
				tick(int'(WAKE_BUS_CYC) + 10);
				bus_rx <= 1'b1;
			end else begin
				high_voltage_wake_input <= 1'b0;
				tick(30);
				high_voltage_wake_input <= 1'b1;
				tick(8);
				check(sleeping, 1'b1);
				high_voltage_wake_input <= 1'b0;
				tick(50);
				high_voltage_wake_input <= 1'b1;
			end
			tick(8);
			check({sleeping, sc_threshold_sel}, {1'b0, SC_THR_RST});
			chip_en <= 1'b1;
			tick(40);
		end
		chip_en <= 1'b0;
		tick(30);
		pulse_sleep();
		tick(80);
		check(sleeping, 1'b1);
		chip_en <= 1'b1;
		tick(40);
		check(sleeping, 1'b0);
		monitor_raw <= 9'h080;
		tick(8);
		pulse_sleep();
		chip_en <= 1'b0;
		tick(60);
		check(sleeping, 1'b0);
		monitor_raw <= 9'h0;
		chip_en <= 1'b1;
		tick(40);
		chip_en <= 1'b0;
		tick(40);
		check(sleeping, 1'b1);
		chip_en <= 1'b1;
		tick(40);
	endtask

	initial begin
		tick(20);
		arst_n <= 1'b1;
		chip_en <= 1'b1;
		tick(40);
		t_dead();
		t_short();
		t_uv();
		t_mon();
		t_standby();
		t_sleep();
		finish_test();
	end
endmodule
`default_nettype wire
